// File: logic/sisu_regs.svh
// Register offsets, field positions, reset values and sizes of the sensor interrupt status unit
//
// Operation
// - Flush write empties FIFO, clears count, flags
// - Reading empty FIFO sets underflow bit 14
// - Full FIFO drops byte, sets overflow bit 13
// - Byte count readable in bits 10 to 0
// - FIFO write above limit sets level bit 15
// - Autoclear clears level flag on data read
// - Slot update sets its new-data flag bit
// - Slot autoclear clears flag on slot read
// - Writing one clears flag, zero keeps it
// - Level 0 criterion sets flag at 0x0002
// - Level 1 criterion sets flag at 0x0003
// - Channel 1 ceiling sets flag at 0x0004
// - Bit n is slot n; 15..12 read zero
// - Autoclear enables, FIFO bit 15, reset to one
// - Enable bits gate flags onto interrupt X
`ifndef SISU_REGS_SVH
`define SISU_REGS_SVH

// Register offsets
`define SISU_OFS_FIFO_STATE   8'h00
`define SISU_OFS_DATA_READY   8'h01
`define SISU_OFS_LEVEL_ZERO   8'h02
`define SISU_OFS_LEVEL_ONE    8'h03
`define SISU_OFS_CH1_CEILING  8'h04
`define SISU_OFS_AUTOCLEAR    8'h07
`define SISU_OFS_IRQ_X_EN     8'h14
`define SISU_OFS_LEVEL_LIMIT  8'h40
`define SISU_OFS_FIFO_DATA    8'h41

// Field positions
`define SISU_BIT_FLUSH        15
`define SISU_BIT_UFLOW        14
`define SISU_BIT_OFLOW        13
`define SISU_BIT_LEVEL        15
`define SISU_BIT_ACLR_FIFO    15
`define SISU_BIT_EN_LEVEL     15
`define SISU_BIT_EN_UFLOW     14
`define SISU_BIT_EN_OFLOW     13
`define SISU_COUNT_MSB        10
`define SISU_SLOT_MSB         11

// Reset values and writable masks
`define SISU_ACLR_RST         16'h8fff
`define SISU_ACLR_MASK        16'h8fff
`define SISU_IRQ_EN_RST       16'h0000
`define SISU_IRQ_EN_MASK      16'hefff
`define SISU_LIMIT_RST        11'h000

// FIFO size in bytes
`define SISU_FIFO_DEPTH       11'h200

`endif

// File: logic/sisu_pkg.sv
// Types shared by the sensor interrupt status unit
package sisu_pkg;

  // Per-slot events raised by the data path during a data register update
  typedef struct packed {
    logic [11:0] upd;   // Slot data registers updated
    logic [11:0] lev0;  // Level 0 criterion met at this update
    logic [11:0] lev1;  // Level 1 criterion met at this update
    logic [11:0] ceil;  // Channel 1 result above ceiling at this update
  } sisu_slot_evt_t;

  // Kind of register read waiting for its answer
  typedef enum logic [1:0] {
    SISU_RD_IDLE = 2'b00,
    SISU_RD_REG  = 2'b01,
    SISU_RD_FIFO = 2'b11
  } sisu_rd_kind_t;

endpackage

// File: logic/sisu_fifo_mem.sv
// Byte storage of the sample FIFO with registered read data
`timescale 1ns/100ps
module sisu_fifo_mem (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       wr_en_i,
  input  wire logic [8:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_en_i,
  input  wire logic [8:0] rd_addr_i,
  output logic      [7:0] rd_data_o
);

  logic [7:0] mem [0:511]; // Storage array, no reset so it maps onto RAM

  // Write port
  always_ff @(posedge clk_i) begin
    if (ce_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Read port; data holds between reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (ce_i && rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// File: logic/sisu_top.sv
// Interrupt status unit: FIFO status flags, per-slot flags, autoclear and interrupt X
`timescale 1ns/100ps
`include "sisu_regs.svh"
module sisu_top (
  input  wire logic                     CLK_I,
  input  wire logic                     RESET_N_I,
  input  wire logic                     CE_I,
  input  wire logic [7:0]               REG_ADDR_I,
  input  wire logic                     REG_WR_I,
  input  wire logic                     REG_RD_I,
  input  wire logic [15:0]              REG_WDATA_I,
  output logic      [15:0]              REG_RDATA_O,
  output logic                          REG_RVALID_O,
  input  wire logic                     FIFO_WR_I,
  input  wire logic [7:0]               FIFO_WDATA_I,
  input  wire sisu_pkg::sisu_slot_evt_t SLOT_EVT_I,
  input  wire logic [11:0]              SLOT_RD_I,
  output logic                          IRQ_X_O
);

  // Register state
  logic [10:0]                   count_q;       // Bytes held in the FIFO
  logic [8:0]                    wr_ptr_q;      // Next byte slot to fill
  logic [8:0]                    rd_ptr_q;      // Next byte slot to drain
  logic                          uflow_q;       // fifo_empty_read_error
  logic                          oflow_q;       // fifo_full_drop_error
  logic                          level_q;       // fifo_level_flag
  logic [11:0]                   ready_q;       // New-data flags, slot A at bit 0
  logic [11:0]                   lev0_q;        // slot_level0_flag per slot
  logic [11:0]                   lev1_q;        // slot_level1_flag per slot
  logic [11:0]                   ceil_q;        // slot_ch1_ceiling_flag per slot
  logic [15:0]                   aclr_q;        // Autoclear enables
  logic [15:0]                   irq_en_q;      // Interrupt X enables
  logic [10:0]                   limit_q;       // fifo_level_limit
  sisu_pkg::sisu_rd_kind_t       rd_kind_q;     // Read waiting for its answer
  logic [15:0]                   rd_hold_q;     // Register value captured at the read

  // Decoded strobes
  logic                          wr_fifo_state; // Write to fifo_state
  logic                          wr_ready;      // Write to data_ready_flags
  logic                          wr_lev0;       // Write to level_zero_flags
  logic                          wr_lev1;       // Write to level_one_flags
  logic                          wr_ceil;       // Write to ch1_ceiling_flags
  logic                          wr_aclr;       // Write to autoclear register
  logic                          wr_irq_en;     // Write to interrupt X enables
  logic                          wr_limit;      // Write to level limit
  logic                          rd_any;        // Any register read taken
  logic                          rd_fifo;       // Read of the FIFO data register
  logic                          flush;         // Flush request this cycle
  logic                          fifo_empty;    // No bytes held
  logic                          fifo_full;     // No free byte
  logic                          push;          // Byte accepted into the FIFO
  logic                          pop;           // Byte taken out of the FIFO
  logic [10:0]                   count_d;       // Next byte count
  logic [7:0]                    mem_rdata;     // Byte read out of storage
  logic [15:0]                   rd_value;      // Value of the addressed register
  logic [11:0]                   slot_aclr;     // Slot flags cleared by a data read
  logic [11:0]                   slot_mask;     // Writable slot bit lanes

  assign slot_mask = 12'hfff;

  // Register decode; every access is frozen while the clock enable is low
  assign wr_fifo_state = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_FIFO_STATE);
  assign wr_ready      = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_DATA_READY);
  assign wr_lev0       = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_LEVEL_ZERO);
  assign wr_lev1       = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_LEVEL_ONE);
  assign wr_ceil       = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_CH1_CEILING);
  assign wr_aclr       = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_AUTOCLEAR);
  assign wr_irq_en     = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_IRQ_X_EN);
  assign wr_limit      = CE_I && REG_WR_I && (REG_ADDR_I == `SISU_OFS_LEVEL_LIMIT);
  assign rd_any        = CE_I && REG_RD_I;
  assign rd_fifo       = rd_any && (REG_ADDR_I == `SISU_OFS_FIFO_DATA);

  // Flush is a write of one to the flush bit
  assign flush = wr_fifo_state && REG_WDATA_I[`SISU_BIT_FLUSH];

  // FIFO occupancy
  assign fifo_empty = (count_q == 11'h000);
  assign fifo_full  = (count_q == `SISU_FIFO_DEPTH);

  // A byte arriving at a full FIFO is dropped; a flush also drops it
  assign push = CE_I && FIFO_WR_I && !fifo_full && !flush;
  // Reads of an empty FIFO take nothing out; host keeps reads and flush apart
  assign pop  = rd_fifo && !fifo_empty;

  // Next count; flush wins over any traffic in the same cycle
  always_comb begin
    if (flush) begin
      count_d = 11'h000;
    end else begin
      count_d = count_q + {10'h000, push} - {10'h000, pop};
    end
  end

  // Byte count and pointers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      count_q  <= 11'h000;
      wr_ptr_q <= 9'h000;
      rd_ptr_q <= 9'h000;
    end else if (CE_I) begin
      count_q <= count_d;
      if (flush) begin
        // Emptying by pointer reset; stored bytes are simply abandoned
        wr_ptr_q <= 9'h000;
        rd_ptr_q <= 9'h000;
      end else begin
        wr_ptr_q <= wr_ptr_q + {8'h00, push};
        rd_ptr_q <= rd_ptr_q + {8'h00, pop};
      end
    end
  end

  // FIFO byte storage
  sisu_fifo_mem u_mem (
    .clk_i     (CLK_I),
    .rst_n_i   (RESET_N_I),
    .ce_i      (CE_I),
    .wr_en_i   (push),
    .wr_addr_i (wr_ptr_q),
    .wr_data_i (FIFO_WDATA_I),
    .rd_en_i   (pop),
    .rd_addr_i (rd_ptr_q),
    .rd_data_o (mem_rdata)
  );

  // Underflow flag; a new error beats a clear in the same cycle
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      uflow_q <= 1'b0;
    end else if (CE_I) begin
      if (rd_fifo && fifo_empty) begin
        uflow_q <= 1'b1;
      end else if (flush || (wr_fifo_state && REG_WDATA_I[`SISU_BIT_UFLOW])) begin
        uflow_q <= 1'b0;
      end
    end
  end

  // Overflow flag; a byte dropped at a full FIFO beats a clear in the same cycle
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      oflow_q <= 1'b0;
    end else if (CE_I) begin
      if (FIFO_WR_I && fifo_full) begin
        oflow_q <= 1'b1;
      end else if (flush || (wr_fifo_state && REG_WDATA_I[`SISU_BIT_OFLOW])) begin
        oflow_q <= 1'b0;
      end
    end
  end

  // Fill-level flag: set by a write that leaves more bytes than the limit
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      level_q <= 1'b0;
    end else if (CE_I) begin
      if (push && (count_d > limit_q)) begin
        level_q <= 1'b1;
      end else if (flush || (wr_ready && REG_WDATA_I[`SISU_BIT_LEVEL])) begin
        level_q <= 1'b0;
      end else if (rd_fifo && aclr_q[`SISU_BIT_ACLR_FIFO]) begin
        level_q <= 1'b0;
      end
    end
  end

  // Slot data reads clear new-data flags only where autoclear is on
  assign slot_aclr = CE_I ? (SLOT_RD_I & aclr_q[`SISU_SLOT_MSB:0]) : 12'h000;

  // New-data flags; the update term is ORed last so a set always wins
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ready_q <= 12'h000;
    end else if (CE_I) begin
      ready_q <= (ready_q & ~((wr_ready ? REG_WDATA_I[`SISU_SLOT_MSB:0] : 12'h000) | slot_aclr))
                 | SLOT_EVT_I.upd;
    end
  end

  // Level 0 flags, set only during a slot update that meets the criterion
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lev0_q <= 12'h000;
    end else if (CE_I) begin
      lev0_q <= (lev0_q & ~(wr_lev0 ? REG_WDATA_I[`SISU_SLOT_MSB:0] : 12'h000))
                | (SLOT_EVT_I.upd & SLOT_EVT_I.lev0);
    end
  end

  // Level 1 flags
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lev1_q <= 12'h000;
    end else if (CE_I) begin
      lev1_q <= (lev1_q & ~(wr_lev1 ? REG_WDATA_I[`SISU_SLOT_MSB:0] : 12'h000))
                | (SLOT_EVT_I.upd & SLOT_EVT_I.lev1);
    end
  end

  // Channel 1 ceiling flags
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ceil_q <= 12'h000;
    end else if (CE_I) begin
      ceil_q <= (ceil_q & ~(wr_ceil ? REG_WDATA_I[`SISU_SLOT_MSB:0] : 12'h000))
                | (SLOT_EVT_I.upd & SLOT_EVT_I.ceil);
    end
  end

  // Autoclear enables start on so flags drain with plain data reads
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aclr_q <= `SISU_ACLR_RST;
    end else if (wr_aclr) begin
      aclr_q <= REG_WDATA_I & `SISU_ACLR_MASK;
    end
  end

  // Interrupt X enables
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_en_q <= `SISU_IRQ_EN_RST;
    end else if (wr_irq_en) begin
      irq_en_q <= REG_WDATA_I & `SISU_IRQ_EN_MASK;
    end
  end

  // Fill-level limit
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      limit_q <= `SISU_LIMIT_RST;
    end else if (wr_limit) begin
      limit_q <= REG_WDATA_I[10:0];
    end
  end

  // Interrupt X: any enabled status flag holds it high
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      IRQ_X_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_X_O <= (level_q && irq_en_q[`SISU_BIT_EN_LEVEL])
                 || (uflow_q && irq_en_q[`SISU_BIT_EN_UFLOW])
                 || (oflow_q && irq_en_q[`SISU_BIT_EN_OFLOW])
                 || |(ready_q & irq_en_q[`SISU_SLOT_MSB:0]);
    end
  end

  // Read value; reserved bits and unmapped offsets read as zero
  always_comb begin
    rd_value = 16'h0000;
    case (REG_ADDR_I)
      `SISU_OFS_FIFO_STATE: begin
        // Flush bit always reads back as zero
        rd_value[`SISU_BIT_UFLOW]       = uflow_q;
        rd_value[`SISU_BIT_OFLOW]       = oflow_q;
        rd_value[`SISU_COUNT_MSB:0]     = count_q;
      end
      `SISU_OFS_DATA_READY: begin
        rd_value[`SISU_BIT_LEVEL]       = level_q;
        rd_value[`SISU_SLOT_MSB:0]      = ready_q & slot_mask;
      end
      `SISU_OFS_LEVEL_ZERO: begin
        rd_value[`SISU_SLOT_MSB:0]      = lev0_q;
      end
      `SISU_OFS_LEVEL_ONE: begin
        rd_value[`SISU_SLOT_MSB:0]      = lev1_q;
      end
      `SISU_OFS_CH1_CEILING: begin
        rd_value[`SISU_SLOT_MSB:0]      = ceil_q;
      end
      `SISU_OFS_AUTOCLEAR: begin
        rd_value = aclr_q;
      end
      `SISU_OFS_IRQ_X_EN: begin
        rd_value = irq_en_q;
      end
      `SISU_OFS_LEVEL_LIMIT: begin
        rd_value[10:0] = limit_q;
      end
      default: begin
        rd_value = 16'h0000;
      end
    endcase
  end

  // First read stage: capture the value and the kind of read
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_kind_q <= sisu_pkg::SISU_RD_IDLE;
      rd_hold_q <= 16'h0000;
    end else if (CE_I) begin
      rd_hold_q <= rd_value;
      if (rd_fifo && !fifo_empty) begin
        rd_kind_q <= sisu_pkg::SISU_RD_FIFO;
      end else if (rd_any) begin
        rd_kind_q <= sisu_pkg::SISU_RD_REG;
      end else begin
        rd_kind_q <= sisu_pkg::SISU_RD_IDLE;
      end
    end
  end

  // Second read stage; every read answers two edges after it is taken,
  // which lets the storage read data settle without a combinational path
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O  <= 16'h0000;
      REG_RVALID_O <= 1'b0;
    end else if (CE_I) begin
      case (rd_kind_q)
        sisu_pkg::SISU_RD_FIFO: begin
          REG_RDATA_O  <= {8'h00, mem_rdata};
          REG_RVALID_O <= 1'b1;
        end
        sisu_pkg::SISU_RD_REG: begin
          REG_RDATA_O  <= rd_hold_q;
          REG_RVALID_O <= 1'b1;
        end
        default: begin
          REG_RVALID_O <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: verification/sisu_chk_sva.sv
// Port-level assertions for the interrupt status unit
`timescale 1ns/100ps
module sisu_chk (
  input wire logic                     CLK_I,
  input wire logic                     RESET_N_I,
  input wire logic                     CE_I,
  input wire logic [7:0]               REG_ADDR_I,
  input wire logic                     REG_WR_I,
  input wire logic                     REG_RD_I,
  input wire logic [15:0]              REG_WDATA_I,
  input wire logic [15:0]              REG_RDATA_O,
  input wire logic                     REG_RVALID_O,
  input wire logic                     FIFO_WR_I,
  input wire logic [7:0]               FIFO_WDATA_I,
  input wire sisu_pkg::sisu_slot_evt_t SLOT_EVT_I,
  input wire logic [11:0]              SLOT_RD_I,
  input wire logic                     IRQ_X_O
);
  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // A register read taken at one edge
  sequence s_rd(logic [7:0] a);
    CE_I && REG_RD_I && REG_ADDR_I == a;
  endsequence

  // Quiet cycle: no register access, FIFO write or slot read; slot updates may still set flags
  sequence s_gap;
    CE_I && !REG_WR_I && !REG_RD_I && !FIFO_WR_I && SLOT_RD_I == 12'h000;
  endsequence

  chk_read_latency: assert property ((CE_I && REG_RD_I) ##1 CE_I |-> ##1 REG_RVALID_O)
    else $error("read answer not two edges after request");
  chk_answer_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I, 2))
    else $error("answer without a read");
  chk_rdata_hold: assert property (!REG_RVALID_O |-> $stable(REG_RDATA_O))
    else $error("read data moved between answers");
  chk_slot_rsvd: assert property (
    (CE_I && REG_RD_I && REG_ADDR_I inside {8'h02, 8'h03, 8'h04}) ##1 CE_I |-> ##1 REG_RDATA_O[15:12] == 4'h0)
    else $error("slot register reserved bits not zero");
  chk_count_rsvd: assert property (s_rd(8'h00) ##1 CE_I |-> ##1 REG_RDATA_O[12:11] == 2'b00)
    else $error("fifo state reserved bits not zero");
  // Bits of a slot update must show in the next read of the ready flags
  chk_upd_seen: assert property (
    (CE_I && SLOT_EVT_I.upd != 12'h000) ##1 s_gap ##1 s_rd(8'h01) ##1 CE_I
    |-> ##1 (REG_RDATA_O[11:0] & $past(SLOT_EVT_I.upd, 4)) == $past(SLOT_EVT_I.upd, 4))
    else $error("slot update flag missing");
  chk_set_wins: assert property (
    (CE_I && SLOT_EVT_I.upd[0] && SLOT_RD_I[0]) ##1 s_gap ##1 s_rd(8'h01) ##1 CE_I |-> ##1 REG_RDATA_O[0])
    else $error("autoclear beat a same-cycle set");
  chk_flush_clear: assert property (
    (CE_I && REG_WR_I && REG_ADDR_I == 8'h00 && REG_WDATA_I[15]) ##1 s_gap ##1 s_rd(8'h00) ##1 CE_I
    |-> ##1 REG_RDATA_O[14:0] == 15'h0000)
    else $error("flush left count or error flags");
  chk_irq_masked: assert property (
    (CE_I && REG_WR_I && REG_ADDR_I == 8'h14 && REG_WDATA_I == 16'h0000) ##1 (CE_I && !REG_WR_I) |-> ##1 !IRQ_X_O)
    else $error("interrupt high with all enables clear");
endmodule

bind sisu_top sisu_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .REG_RVALID_O(REG_RVALID_O), .FIFO_WR_I(FIFO_WR_I), .FIFO_WDATA_I(FIFO_WDATA_I), .SLOT_EVT_I(SLOT_EVT_I),
  .SLOT_RD_I(SLOT_RD_I), .IRQ_X_O(IRQ_X_O));

// File: verification/sisu_host_bfm.sv
// Host side of the register port, one transfer at a time
`timescale 1ns/100ps
module sisu_host_bfm (
  input  wire logic        clk_i,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i,
  output logic      [7:0]  reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [15:0] reg_wdata_o
);
  // Idle bus from time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // Write strobe held across exactly one rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
  endtask

  // Transfers never overlap, so a flush cannot land inside a read
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_i);
    reg_rd_o   = 1'b0;
    // Bounded wait for the answer pulse
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      #1;
      if (reg_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata_i;
      end
    end
  endtask
endmodule

// File: verification/sensor_irq_status_unit_tb.sv
// Self-checking bench for the interrupt status unit with a behavioural model
`timescale 1ns/100ps
module sensor_irq_status_unit_tb;
  logic                     clk;
  logic                     rst_n;
  logic                     ce;           // Clock enable, dropped once to prove the freeze
  logic                     fifo_wr;
  logic [7:0]               fifo_wdata;
  sisu_pkg::sisu_slot_evt_t slot_evt;
  logic [11:0]              slot_rd;
  logic [7:0]               reg_addr;
  logic                     reg_wr, reg_rd, reg_rvalid, irq_x;
  logic [15:0]              reg_wdata, reg_rdata;
  int                       n_fail, check_count;
  logic [31:0]              seed, r1, r2, r3;
  // Model state: flag registers, enables, limit and FIFO bytes
  logic [15:0]              m_dat, m_lv0, m_lv1, m_cel, m_aclr, m_en;
  logic                     m_uf, m_of;
  logic [10:0]              m_lim;
  logic [7:0]               m_q[$];
  logic [7:0]               addr_tab[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h14};

  sisu_top u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata), .REG_RVALID_O(reg_rvalid),
    .FIFO_WR_I(fifo_wr), .FIFO_WDATA_I(fifo_wdata), .SLOT_EVT_I(slot_evt), .SLOT_RD_I(slot_rd), .IRQ_X_O(irq_x));
  sisu_host_bfm u_host (.clk_i(clk), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected read value; a FIFO data read also moves the model
  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      8'h00: r = {1'b0, m_uf, m_of, 2'b00, 11'(m_q.size())};
      8'h01: r = m_dat;
      8'h02: r = m_lv0;
      8'h03: r = m_lv1;
      8'h04: r = m_cel;
      8'h07: r = m_aclr;
      8'h14: r = m_en;
      8'h40: r = {5'h00, m_lim};
      8'h41: begin
        if (m_q.size() == 0) m_uf = 1'b1;
        else r = {8'h00, m_q.pop_front()};
        if (m_aclr[15]) m_dat[15] = 1'b0;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  task automatic rd_cmp(input logic [7:0] a);
    logic [15:0] e;
    logic [15:0] d;
    logic        ok;
    e = exp_rd(a);
    u_host.rd_reg(a, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: no answer to read of %h", $time, a);
      complete_run();
    end else check(d, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.wr_reg(a, d);
    case (a)
      8'h00: begin
        if (d[15]) m_q.delete();
        if (d[15]) m_dat[15] = 1'b0;
        if (d[15] | d[14]) m_uf = 1'b0;
        if (d[15] | d[13]) m_of = 1'b0;
      end
      8'h01: m_dat &= ~(d & 16'h8fff);
      8'h02: m_lv0 &= ~(d & 16'h0fff);
      8'h03: m_lv1 &= ~(d & 16'h0fff);
      8'h04: m_cel &= ~(d & 16'h0fff);
      8'h07: m_aclr = d & 16'h8fff;
      8'h14: m_en = d & 16'hefff;
      8'h40: m_lim = d[10:0];
      default: ;
    endcase
  endtask

  // One-cycle slot update with host slot reads; set applied after clear
  task automatic evt(input logic [11:0] u, l0, l1, c, s);
    @(negedge clk);
    slot_evt = {u, l0, l1, c};
    slot_rd  = s;
    @(negedge clk);
    slot_evt = '0;
    slot_rd  = 12'h000;
    m_dat[11:0] &= ~(s & m_aclr[11:0]);
    m_dat[11:0] |= u;
    m_lv0[11:0] |= u & l0;
    m_lv1[11:0] |= u & l1;
    m_cel[11:0] |= u & c;
  endtask

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    fifo_wr    = 1'b1;
    fifo_wdata = b;
    @(negedge clk);
    fifo_wr    = 1'b0;
    if (m_q.size() == 512) m_of = 1'b1;
    else begin
      m_q.push_back(b);
      if (m_q.size() > m_lim) m_dat[15] = 1'b1;
    end
  endtask

  // Interrupt follows enabled flags after the register delays
  task automatic chk_irq();
    logic e;
    e = |(m_en & {m_dat[15], m_uf, m_of, 1'b0, m_dat[11:0]});
    repeat (3) @(negedge clk);
    check({15'h0000, irq_x}, {15'h0000, e});
  endtask

  initial begin
    {rst_n, fifo_wr, fifo_wdata, slot_rd} = '0;
    ce = 1'b1;
    slot_evt = '0;
    {n_fail, check_count} = '0;
    seed = 32'h0000002f;
    {m_dat, m_lv0, m_lv1, m_cel, m_en, m_uf, m_of, m_lim} = '0;
    m_aclr = 16'h8fff;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    foreach (addr_tab[i]) rd_cmp(addr_tab[i]);
    rd_cmp(8'h00);
    rd_cmp(8'h40);
    rd_cmp(8'h33);
    // Clock enable low: a byte and a slot update must both be ignored;
    // wait until the last answer pulse is gone so it is not frozen high
    repeat (2) @(negedge clk);
    ce           = 1'b0;
    fifo_wr      = 1'b1;
    slot_evt.upd = 12'hfff;
    repeat (3) @(negedge clk);
    ce           = 1'b1;
    fifo_wr      = 1'b0;
    slot_evt     = '0;
    rd_cmp(8'h00);
    rd_cmp(8'h01);
    $display("reset values test done");
    for (int i = 0; i < 80; i++) begin
      r1 = rnd();
      r2 = rnd();
      r3 = rnd();
      if (r3[1:0] == 2'b00) wr(addr_tab[r3[31:8] % 6], r1[31:16] ^ r2[15:0]);
      evt(r1[11:0], r1[27:16], r2[11:0], r2[27:16], r3[23:12] & r1[11:0]);
      for (int a = 1; a < 5; a++) rd_cmp(8'(a));
      chk_irq();
    end
    $display("slot flag test done");
    wr(8'h07, 16'h8fff);
    wr(8'h40, 16'h0005);
    wr(8'h14, 16'he000);
    for (int i = 0; i < 8; i++) begin
      r1 = rnd();
      push(r1[7:0]);
    end
    rd_cmp(8'h00);
    rd_cmp(8'h01);
    chk_irq();
    for (int i = 0; i < 10; i++) rd_cmp(8'h41);
    rd_cmp(8'h00);
    chk_irq();
    wr(8'h00, 16'h4000);
    rd_cmp(8'h00);
    for (int i = 0; i < 513; i++) begin
      r1 = rnd();
      push(r1[7:0]);
    end
    rd_cmp(8'h00);
    chk_irq();
    // Masking is tried while level and overflow flags are still up
    wr(8'h14, 16'h0000);
    chk_irq();
    wr(8'h14, 16'he000);
    wr(8'h00, 16'h8000);
    rd_cmp(8'h00);
    rd_cmp(8'h01);
    chk_irq();
    $display("fifo test done");
    complete_run();
  end
endmodule
